// [hw/itx_top.sv]
`timescale 1ns/1ps
module itx_top (
    input wire logic mclk,
    input wire logic rst_b,
    input wire itx_pkg::itx_req_t req,
    output logic [7:0] rdata,
    input wire logic scl_i,
    input wire logic sda_i,
    output itx_pkg::itx_pins_t pins,
    output logic irq
);
    logic [1:0] pin_sync;
    logic scl_s;
    logic sda_s;
    logic tick;
    logic [7:0] ctl, next_ctl;
    logic [7:0] brg, next_brg;
    logic [7:0] dreg, next_dreg;
    logic tx_data_reg_empty, next_tx_data_reg_empty;
    logic ack, next_ack;
    logic not_ack_irq_flag, next_not_ack_irq_flag;
    logic [7:0] shreg, next_shreg;
    logic [2:0] bitn, next_bitn;
    logic [1:0] phase, next_phase;
    logic first, next_first;
    logic stop_count_signal, next_stop_count_signal;
    logic [7:0] next_rdata;
    logic next_irq;
    itx_pkg::itx_state_t st, next_st;
    itx_pkg::itx_pins_t next_pins;
    logic busy;

    itx_sync #(.W(2)) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .d({scl_i, sda_i}),
        .q(pin_sync)
    );
    assign scl_s = pin_sync[1];
    assign sda_s = pin_sync[0];
    assign busy = (st != itx_pkg::ST_IDLE);

    itx_tick u_tick (
        .mclk(mclk),
        .rst_b(rst_b),
        .run(ctl[itx_pkg::CTL_EN]),
        .div(brg),
        .tick(tick)
    );

    always_comb begin
        next_ctl = ctl;
        next_brg = brg;
        next_dreg = dreg;
        next_tx_data_reg_empty = tx_data_reg_empty;
        next_ack = ack;
        next_not_ack_irq_flag = not_ack_irq_flag;
        next_shreg = shreg;
        next_bitn = bitn;
        next_phase = phase;
        next_first = first;
        next_stop_count_signal = stop_count_signal;
        next_st = st;
        next_pins = pins;
        next_rdata = 8'h00;
        if (req.wr) begin
            case (req.addr)
                itx_pkg::ADDR_DATA: begin
                    next_dreg = req.wdata;
                    next_tx_data_reg_empty = 1'b0;
                end
                itx_pkg::ADDR_CTL: next_ctl = req.wdata;
                itx_pkg::ADDR_BRG: next_brg = req.wdata;
                default: ;
            endcase
        end
        if (next_ctl[itx_pkg::CTL_FLUSH]) begin
            next_tx_data_reg_empty = 1'b1;
            next_ctl[itx_pkg::CTL_FLUSH] = 1'b0;
        end
        if (req.rd) begin
            case (req.addr)
                itx_pkg::ADDR_DATA: next_rdata = dreg;
                itx_pkg::ADDR_CTL: next_rdata = ctl;
                itx_pkg::ADDR_BRG: next_rdata = brg;
                itx_pkg::ADDR_STAT: begin
                    next_rdata[itx_pkg::STAT_TX_DATA_REG_EMPTY] = tx_data_reg_empty;
                    next_rdata[itx_pkg::STAT_ACK] = ack;
                    next_rdata[itx_pkg::STAT_NOT_ACK_IRQ_FLAG] = not_ack_irq_flag;
                    next_rdata[itx_pkg::STAT_BUSY] = busy;
                end
                itx_pkg::ADDR_DIAG: begin
                    next_rdata[itx_pkg::DIAG_SCL] = scl_s;
                    next_rdata[itx_pkg::DIAG_SDA] = sda_s;
                    next_rdata[itx_pkg::DIAG_STOP_COUNT_SIGNAL] = stop_count_signal;
                    next_rdata[4:0] = st;
                end
                default: next_rdata = 8'h00;
            endcase
        end
        // Phases: 0 SCL low set SDA, 1 raise SCL, 2 sample, 3 drop SCL
        if (tick) begin
            next_phase = phase + 2'd1;
            case (st)
                itx_pkg::ST_IDLE: begin
                    next_phase = 2'd0;
                    next_pins = '{scl_o: 1'b1, scl_oe: 1'b0, sda_o: 1'b1, sda_oe: 1'b0};
                    if (ctl[itx_pkg::CTL_START] && !tx_data_reg_empty) begin
                        next_st = itx_pkg::ST_START;
                        next_stop_count_signal = 1'b0;
                    end else if (ctl[itx_pkg::CTL_STOP]) begin
                        next_ctl[itx_pkg::CTL_STOP] = 1'b0;
                        next_not_ack_irq_flag = 1'b0;
                    end
                end
                itx_pkg::ST_START: begin
                    if (phase == 2'd1) begin
                        next_pins.sda_o = 1'b0;
                        next_pins.sda_oe = 1'b1;
                    end else if (phase == 2'd3) begin
                        next_pins.scl_o = 1'b0;
                        next_pins.scl_oe = 1'b1;
                        next_ctl[itx_pkg::CTL_START] = 1'b0;
                        next_shreg = dreg;
                        next_tx_data_reg_empty = 1'b1;
                        next_bitn = 3'd7;
                        next_first = 1'b1;
                        next_st = itx_pkg::ST_A1BIT;
                    end
                end
                itx_pkg::ST_A1BIT, itx_pkg::ST_DBIT: begin
                    if (phase == 2'd0) begin
                        next_pins.sda_o = shreg[bitn];
                        next_pins.sda_oe = !shreg[bitn];
                    end else if (phase == 2'd1) begin
                        next_pins.scl_o = 1'b1;
                        next_pins.scl_oe = 1'b0;
                    end else if (phase == 2'd3) begin
                        next_pins.scl_o = 1'b0;
                        next_pins.scl_oe = 1'b1;
                        if (bitn == 3'd0) begin
                            next_st = first ? itx_pkg::ST_A2ACK : itx_pkg::ST_DACK;
                        end
                        next_bitn = bitn - 3'd1;
                    end
                end
                itx_pkg::ST_A2ACK, itx_pkg::ST_DACK: begin
                    if (phase == 2'd0) begin
                        next_pins.sda_o = 1'b1;
                        next_pins.sda_oe = 1'b0;
                    end else if (phase == 2'd1) begin
                        next_pins.scl_o = 1'b1;
                        next_pins.scl_oe = 1'b0;
                    end else if (phase == 2'd2) begin
                        next_ack = !sda_s;
                        next_not_ack_irq_flag = sda_s;
                    end else begin
                        next_pins.scl_o = 1'b0;
                        next_pins.scl_oe = 1'b1;
                        next_first = 1'b0;
                        next_st = ack ? itx_pkg::ST_DBIT : itx_pkg::ST_NACK2;
                        if (ack && tx_data_reg_empty) begin
                            next_phase = 2'd3;
                            next_st = st;
                        end else if (ack) begin
                            next_shreg = dreg;
                            next_tx_data_reg_empty = 1'b1;
                            next_bitn = 3'd7;
                        end
                        // Held clock leaves phase at 3; STOP must start from phase 0
                        if (ctl[itx_pkg::CTL_STOP]) begin
                            next_st = itx_pkg::ST_STOP1;
                            next_phase = 2'd0;
                        end
                    end
                end
                itx_pkg::ST_NACK2: begin
                    next_phase = 2'd0;
                    if (ctl[itx_pkg::CTL_STOP]) begin
                        next_st = itx_pkg::ST_STOP1;
                    end
                end
                itx_pkg::ST_STOP1: begin
                    // STOP: SDA low then rise under SCL high
                    next_pins.sda_o = 1'b0;
                    next_pins.sda_oe = 1'b1;
                    if (phase == 2'd3) begin
                        next_pins.scl_o = 1'b1;
                        next_pins.scl_oe = 1'b0;
                        next_st = itx_pkg::ST_STOP2;
                    end
                end
                itx_pkg::ST_STOP2: begin
                    if (phase == 2'd3) begin
                        next_pins.sda_o = 1'b1;
                        next_pins.sda_oe = 1'b0;
                        next_ctl[itx_pkg::CTL_STOP] = 1'b0;
                        next_not_ack_irq_flag = 1'b0;
                        next_stop_count_signal = 1'b1;
                        next_st = itx_pkg::ST_IDLE;
                    end
                end
                default: next_st = itx_pkg::ST_IDLE;
            endcase
        end
        if (!ctl[itx_pkg::CTL_EN]) begin
            next_st = itx_pkg::ST_IDLE;
            next_phase = 2'd0;
            next_pins = '{scl_o: 1'b1, scl_oe: 1'b0, sda_o: 1'b1, sda_oe: 1'b0};
        end
        next_irq = next_ctl[itx_pkg::CTL_TXI] & next_tx_data_reg_empty | next_not_ack_irq_flag;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctl <= itx_pkg::CTL_RESET;
            brg <= itx_pkg::BRG_RESET;
            dreg <= 8'h00;
            tx_data_reg_empty <= 1'b1;
            ack <= 1'b0;
            not_ack_irq_flag <= 1'b0;
            shreg <= 8'h00;
            bitn <= 3'd7;
            phase <= 2'd0;
            first <= 1'b0;
            stop_count_signal <= 1'b0;
            st <= itx_pkg::ST_IDLE;
            pins <= '{scl_o: 1'b1, scl_oe: 1'b0, sda_o: 1'b1, sda_oe: 1'b0};
            rdata <= 8'h00;
            irq <= 1'b0;
        end else begin
            ctl <= next_ctl;
            brg <= next_brg;
            dreg <= next_dreg;
            tx_data_reg_empty <= next_tx_data_reg_empty;
            ack <= next_ack;
            not_ack_irq_flag <= next_not_ack_irq_flag;
            shreg <= next_shreg;
            bitn <= next_bitn;
            phase <= next_phase;
            first <= next_first;
            stop_count_signal <= next_stop_count_signal;
            st <= next_st;
            pins <= next_pins;
            rdata <= next_rdata;
            irq <= next_irq;
        end
    end

    chk_irq_tx_data_reg_empty: assert property (@(posedge mclk) disable iff (!rst_b)
        ctl[itx_pkg::CTL_TXI] && tx_data_reg_empty |-> irq)
        else $error("irq missing while empty");
    chk_start_go: assert property (@(posedge mclk) disable iff (!rst_b)
        tick && st == itx_pkg::ST_IDLE && ctl[itx_pkg::CTL_START] && !tx_data_reg_empty
        && ctl[itx_pkg::CTL_EN] |=> st == itx_pkg::ST_START)
        else $error("start not taken");
    chk_load_empty: assert property (@(posedge mclk) disable iff (!rst_b)
        $changed(shreg) |-> tx_data_reg_empty)
        else $error("shift load kept data");
    chk_ack_set: assert property (@(posedge mclk) disable iff (!rst_b)
        tick && phase == 2'd2 && st == itx_pkg::ST_DACK && !sda_s |=> ack && !not_ack_irq_flag)
        else $error("ack not set");
    chk_nack_set: assert property (@(posedge mclk) disable iff (!rst_b)
        tick && phase == 2'd2 && st == itx_pkg::ST_A2ACK && sda_s |=> not_ack_irq_flag && !ack)
        else $error("nack not flagged");
    chk_stop_clr: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(busy) && $past(st) == itx_pkg::ST_STOP2 |-> !not_ack_irq_flag && stop_count_signal
        && !ctl[itx_pkg::CTL_STOP])
        else $error("stop flags not cleared");
    chk_full_byte: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(st == itx_pkg::ST_DACK) |-> $past(bitn) == 3'd0)
        else $error("ack before full byte");
    chk_hold_low: assert property (@(posedge mclk) disable iff (!rst_b)
        tick && st == itx_pkg::ST_DACK && phase == 2'd3 && tx_data_reg_empty && ack
        && ctl[itx_pkg::CTL_EN] |=> pins.scl_oe)
        else $error("scl released while empty");
endmodule : itx_top

// [hw/itx_pkg.sv]
// Notes on behaviour
// - Interrupt raised while transmit interrupts enabled and data register empty.
// - Setting the start bit with the data register loaded makes the controller drive a START.
// - At each acknowledged byte boundary data register moves to shift register, leaving empty.
// - When a loaded byte moves to the shift register, transmit interrupt asserts again.
// - Remaining address bits and write bit shift out MSB first.
// - Slave pulls SDA low in SCL high after byte; controller sets ack.
// - On not-acknowledge set not-ack flag and clear ack.
// - Stop bit drives STOP, then clears stop and not-ack flag.
// - Second address byte shifts out, interrupt as it loads, before its first bit.
// - Every loaded byte fully shifts out before acknowledge is sampled.
// - Diagnostic bit 7 is live SCL input, bit 6 live SDA input.
// - Diagnostic bit 5 is the stop-count signal.
// - Diagnostic low five bits show state code, zero after reset, at F55H.
// - State codes: idle 0, START 1, data ack 10, first STOP 12.
package itx_pkg;
    localparam logic [11:0] ADDR_DATA = 12'hF50;
    localparam logic [11:0] ADDR_STAT = 12'hF51;
    localparam logic [11:0] ADDR_CTL = 12'hF52;
    localparam logic [11:0] ADDR_BRG = 12'hF53;
    localparam logic [11:0] ADDR_DIAG = 12'hF55;
    // Control fields
    localparam int CTL_EN = 7;
    localparam int CTL_START = 6;
    localparam int CTL_STOP = 5;
    localparam int CTL_TXI = 3;
    localparam int CTL_FLUSH = 1;
    // Status and diagnostic fields
    localparam int STAT_TX_DATA_REG_EMPTY = 7;
    localparam int STAT_ACK = 6;
    localparam int STAT_NOT_ACK_IRQ_FLAG = 2;
    localparam int STAT_BUSY = 0;
    localparam int DIAG_SCL = 7;
    localparam int DIAG_SDA = 6;
    localparam int DIAG_STOP_COUNT_SIGNAL = 5;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] BRG_RESET = 8'h0A;
    // Bus rate 100 kHz, quarter period at 40 MHz
    localparam int CLK_HZ = 40000000;
    localparam int BUS_HZ = 100000;
    localparam int QUARTER_CYC = CLK_HZ / (BUS_HZ * 4);

    typedef enum logic [4:0] {
        ST_IDLE = 5'h00,
        ST_START = 5'h01,
        ST_DBIT = 5'h02,
        ST_DACK = 5'h0A,
        ST_NACK2 = 5'h0B,
        ST_STOP1 = 5'h0C,
        ST_STOP2 = 5'h0D,
        ST_A2ACK = 5'h0E,
        ST_A1BIT = 5'h10
    } itx_state_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } itx_req_t;

    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } itx_pins_t;
endpackage : itx_pkg

// [hw/itx_sync.sv]
`timescale 1ns/1ps
module itx_sync #(
    parameter int W = 2
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;
    always_comb begin
        next_meta = d;
        next_q = meta;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= {W{1'b1}};
            q <= {W{1'b1}};
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule : itx_sync

// [hw/itx_tick.sv]
`timescale 1ns/1ps
module itx_tick (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [7:0] div,
    output logic tick
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic next_tick;
    always_comb begin
        next_cnt = cnt;
        next_tick = 1'b0;
        if (!run) begin
            next_cnt = 8'h00;
        end else if (cnt >= div) begin
            next_cnt = 8'h00;
            next_tick = 1'b1;
        end else begin
            next_cnt = cnt + 8'h01;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 8'h00;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule : itx_tick

// [dv/itx_slave.sv]
`timescale 1ns/1ps
module itx_slave (
    input wire logic scl,
    input wire logic sda,
    input wire logic [1:0] nack_at,
    output logic sda_oe,
    output logic in_ack,
    output logic [7:0] last_byte,
    output int nbytes,
    output int nstops
);
    int cnt;
    logic [7:0] sh;

    initial begin
        sda_oe = 1'b0;
        in_ack = 1'b0;
        cnt = 0;
        sh = 8'h00;
        last_byte = 8'h00;
        nbytes = 0;
        nstops = 0;
    end

    // Frame start restarts byte counting
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            cnt = 0;
            nbytes = 0;
            in_ack = 1'b0;
        end
    end

    always @(posedge sda) begin
        if (scl === 1'b1) begin
            nstops++;
        end
    end

    always @(posedge scl) begin
        if (!in_ack) begin
            sh = {sh[6:0], sda};
            cnt++;
        end
    end

    always @(negedge scl) begin
        if (in_ack) begin
            sda_oe = 1'b0;
            in_ack = 1'b0;
            cnt = 0;
        end else if (cnt == 8) begin
            last_byte = sh;
            nbytes++;
            in_ack = 1'b1;
            sda_oe = (nbytes != nack_at);
        end
    end
endmodule : itx_slave

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
    logic mclk;
    logic rst_b;
    itx_pkg::itx_req_t req;
    logic [7:0] rdata;
    itx_pkg::itx_pins_t pins;
    logic irq;
    logic scl_w;
    logic sda_w;
    logic slv_oe;
    logic slv_in_ack;
    logic [7:0] slv_byte;
    int slv_bytes;
    int slv_stops;
    logic [1:0] nack_at;
    int errors;
    int num_checks;
    logic [7:0] rv;

    // Open-drain wires with pull-ups
    assign scl_w = !pins.scl_oe;
    assign sda_w = !(pins.sda_oe || slv_oe);

    itx_top u_dut (.mclk(mclk), .rst_b(rst_b), .req(req), .rdata(rdata),
        .scl_i(scl_w), .sda_i(sda_w), .pins(pins), .irq(irq));
    itx_slave u_slave (.scl(scl_w), .sda(sda_w), .nack_at(nack_at), .sda_oe(slv_oe),
        .in_ack(slv_in_ack), .last_byte(slv_byte), .nbytes(slv_bytes), .nstops(slv_stops));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [11:0] addr, input logic [7:0] data);
        @(posedge mclk);
        req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] addr, output logic [7:0] data);
        @(posedge mclk);
        req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        @(negedge mclk);
        data = rdata;
    endtask : rd

    function automatic bit cond(input int sel, input int val);
        case (sel)
            0: return irq === 1'b1;
            1: return slv_bytes == val;
            2: return slv_in_ack === 1'b0;
            default: return slv_stops == val;
        endcase
    endfunction : cond

    task automatic wait_for(input int sel, input int val);
        int n;
        n = 0;
        while (!cond(sel, val) && n < 4000) begin
            @(posedge mclk);
            n++;
        end
        check("wait", {7'h00, cond(sel, val)}, 8'h01);
    endtask : wait_for

    task automatic t_reset();
        rd(itx_pkg::ADDR_DIAG, rv);
        check("diag lines", rv & 8'hC0, 8'hC0);
        check("diag state", rv & 8'h1F, 8'h00);
        check("irq", {7'h00, irq}, 8'h00);
        rd(12'hF54, rv);
        check("unmapped", rv, 8'h00);
        rd(itx_pkg::ADDR_BRG, rv);
        check("brg reset", rv, itx_pkg::BRG_RESET);
        // Tick every 2 cycles: 200 ns bus clock
        wr(itx_pkg::ADDR_BRG, 8'h01);
        rd(itx_pkg::ADDR_BRG, rv);
        check("brg", rv, 8'h01);
        wr(itx_pkg::ADDR_CTL, 8'h88);
        wait_for(0, 0);
        rd(itx_pkg::ADDR_STAT, rv);
        check("empty", {7'h00, rv[itx_pkg::STAT_TX_DATA_REG_EMPTY]}, 8'h01);
        // Start with nothing loaded is refused
        wr(itx_pkg::ADDR_CTL, 8'hC8);
        repeat (100) @(posedge mclk);
        rd(itx_pkg::ADDR_DIAG, rv);
        check("refused start", rv, 8'hC0);
        wr(itx_pkg::ADDR_CTL, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic send(input logic [1:0] nk);
        logic [7:0] b [3];
        b = '{8'hF0, 8'h5A, 8'h3C};
        nack_at = nk;
        wr(itx_pkg::ADDR_CTL, 8'h88);
        wr(itx_pkg::ADDR_DATA, b[0]);
        wr(itx_pkg::ADDR_CTL, 8'hC8);
        for (int i = 0; i < 3; i++) begin
            wait_for(0, 0);
            check("bytes at refill", slv_bytes[7:0], i[7:0]);
            if (i < 2) begin
                wr(itx_pkg::ADDR_DATA, b[i + 1]);
            end
            wait_for(1, i + 1);
            check("byte seen", slv_byte, b[i]);
            wait_for(2, 0);
            rd(itx_pkg::ADDR_STAT, rv);
            check("ack flag", {7'h00, rv[itx_pkg::STAT_ACK]}, {7'h00, nk != i + 1});
            check("nack flag", {7'h00, rv[itx_pkg::STAT_NOT_ACK_IRQ_FLAG]}, {7'h00, nk == i + 1});
            if (nk == i + 1) begin
                check("nack irq", {7'h00, irq}, 8'h01);
                rd(itx_pkg::ADDR_DIAG, rv);
                check("nack state", rv & 8'h1F, 8'h0B);
                return;
            end
        end
    endtask : send

    task automatic stop_idle(input logic [7:0] ctl, input int stops);
        wr(itx_pkg::ADDR_CTL, ctl);
        wait_for(3, stops + 1);
        for (int n = 0; n < 50; n++) begin
            rd(itx_pkg::ADDR_DIAG, rv);
            if (rv[4:0] == 5'h00) break;
        end
        check("idle state", rv & 8'h1F, 8'h00);
        check("stop count", {7'h00, rv[itx_pkg::DIAG_STOP_COUNT_SIGNAL]}, 8'h01);
        rd(itx_pkg::ADDR_STAT, rv);
        check("nack cleared", {7'h00, rv[itx_pkg::STAT_NOT_ACK_IRQ_FLAG]}, 8'h00);
        rd(itx_pkg::ADDR_CTL, rv);
        check("stop cleared", {7'h00, rv[itx_pkg::CTL_STOP]}, 8'h00);
        check("irq off", {7'h00, irq}, 8'h00);
    endtask : stop_idle

    task automatic t_ten_bit_write();
        int s;
        logic held;
        s = slv_stops;
        held = 1'b1;
        send(2'd0);
        for (int n = 0; n < 300; n++) begin
            @(posedge mclk);
            held = held & (scl_w === 1'b0);
        end
        check("clock held", {7'h00, held}, 8'h01);
        check("no extra byte", slv_bytes[7:0], 8'h03);
        check("refill irq", {7'h00, irq}, 8'h01);
        rd(itx_pkg::ADDR_DIAG, rv);
        check("live scl", {7'h00, rv[itx_pkg::DIAG_SCL]}, 8'h00);
        check("hold state", rv & 8'h1F, 8'h0A);
        stop_idle(8'hA0, s);
        $display("test ten bit write done");
    endtask : t_ten_bit_write

    task automatic t_nack(input logic [1:0] k);
        int s;
        s = slv_stops;
        send(k);
        stop_idle(8'hA2, s);
        rd(itx_pkg::ADDR_STAT, rv);
        check("flushed", {7'h00, rv[itx_pkg::STAT_TX_DATA_REG_EMPTY]}, 8'h01);
        $display("test nack %0d done", k);
    endtask : t_nack

    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        rst_b = 1'b0;
        req = '0;
        nack_at = 2'd0;
        errors = 0;
        num_checks = 0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_ten_bit_write();
        for (int k = 1; k <= 3; k++) begin
            t_nack(k[1:0]);
        end
        results();
    end

    initial begin
        repeat (50000) @(posedge mclk);
        errors++;
        $display("Error watchdog expected done seen hang");
        results();
    end
endmodule : tb
